//--- design/sahp_host_port.sv
// parallel host port and conversion sequencer of the sampling converter
`timescale 1ns/1ps
module sahp_host_port #(
  parameter int STEPS = sahp_pkg::RES_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic csN,
  input wire logic readConvN,
  input wire logic byteSel,
  input wire logic compIn,
  output logic [sahp_pkg::RES_W-1:0] dacCode,
  output logic sampleHold,
  output logic busyN,
  output sahp_pkg::sahp_bus_t dataBus
);
  import sahp_pkg::*;

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  // one step resolves one bit, so any other step count leaves bits unresolved
  if (STEPS != RES_W) begin : g_bad_steps
    $error("sahp_host_port: STEPS must equal RES_W");
  end
  // the step counter below is four bits wide
  if (STEP_CYC < 1 || STEP_CYC > 16) begin : g_bad_step_cyc
    $error("sahp_host_port: STEP_CYC must lie in 1..16");
  end
  // the start filter counter is eight bits wide
  if (START_CYC < 1 || START_CYC > 256) begin : g_bad_start_cyc
    $error("sahp_host_port: START_CYC must lie in 1..256");
  end
  // the byte view splits the word into two equal halves
  if (RES_W != 2 * BYTE_W) begin : g_bad_byte_w
    $error("sahp_host_port: RES_W must be twice BYTE_W");
  end

  // --------------------------------------------------------------------------
  // pin synchronisation
  // --------------------------------------------------------------------------
  sahp_pins_t pinsRaw;
  sahp_pins_t pins;
  assign pinsRaw = '{csN: csN, readConvN: readConvN, byteSel: byteSel};

  sahp_sync #(
    .W(3),
    .RST_VAL(3'b110)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .clkEn(clkEn),
    .asyncIn(pinsRaw),
    .syncOut(pins)
  );

  // --------------------------------------------------------------------------
  // start detection
  // --------------------------------------------------------------------------
  logic convLow;
  logic [7:0] lowCnt_reg, lowCnt_next;
  logic armed_reg, armed_next;
  logic startCmd;

  // select and read/convert are ORed: the command is the combined low level
  assign convLow = ~(pins.csN | pins.readConvN);

  // a command needs the combined low for the least pulse; armed again only
  // after the combined level returns high, so one low gives one start
  // the filter costs START_CYC cycles of latency but keeps a pin glitch
  // shorter than the least pulse from starting a conversion
  always_comb begin
    lowCnt_next = lowCnt_reg;
    armed_next = armed_reg;
    startCmd = 1'b0;
    if (!convLow) begin
      lowCnt_next = 8'h00;
      armed_next = 1'b1;
    end else if (armed_reg) begin
      if (lowCnt_reg == 8'(START_CYC - 1)) begin
        startCmd = 1'b1;
        armed_next = 1'b0;
      end else begin
        lowCnt_next = lowCnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lowCnt_reg <= 8'h00;
      armed_reg <= 1'b0;
    end else if (clkEn) begin
      lowCnt_reg <= lowCnt_next;
      armed_reg <= armed_next;
    end
  end

  // --------------------------------------------------------------------------
  // successive-approximation sequencer
  // --------------------------------------------------------------------------
  sahp_state_t state_reg, state_next;
  logic [RES_W-1:0] trial_reg, trial_next;
  logic [RES_W-1:0] bitPtr_reg, bitPtr_next;
  logic [RES_W-1:0] result_reg, result_next;
  logic [3:0] stepCnt_reg, stepCnt_next;

  // one-hot bit pointer walks from msb down; comparator high keeps the bit
  // busy falls one edge after the start fires and rises STEPS*STEP_CYC+1
  // edges later, together with the new result; each step keeps or drops
  // its trial bit and then sets the next one down
  always_comb begin
    state_next = state_reg;
    trial_next = trial_reg;
    bitPtr_next = bitPtr_reg;
    result_next = result_reg;
    stepCnt_next = stepCnt_reg;
    case (state_reg)
      SAHP_IDLE: begin
        if (startCmd) begin
          state_next = SAHP_CONV;
          bitPtr_next = {1'b1, {(RES_W-1){1'b0}}};
          trial_next = {1'b1, {(RES_W-1){1'b0}}};
          stepCnt_next = 4'h0;
        end
      end
      SAHP_CONV: begin
        if (startCmd) begin
          // a new command mid-conversion aborts and restarts from scratch
          bitPtr_next = {1'b1, {(RES_W-1){1'b0}}};
          trial_next = {1'b1, {(RES_W-1){1'b0}}};
          stepCnt_next = 4'h0;
        end else if (stepCnt_reg == 4'(STEP_CYC - 1)) begin
          stepCnt_next = 4'h0;
          // drop the trial bit when the code overshoots, then try the next one
          // down; on the last step the shift brings in nothing
          trial_next = (compIn ? trial_reg : (trial_reg & ~bitPtr_reg)) | (bitPtr_reg >> 1);
          bitPtr_next = bitPtr_reg >> 1;
          if (bitPtr_reg[0]) begin
            state_next = SAHP_DONE;
          end
        end else begin
          stepCnt_next = stepCnt_reg + 4'h1;
        end
      end
      SAHP_DONE: begin
        if (startCmd) begin
          // busy is still low here, so a late command aborts as well and the
          // finished code is thrown away
          state_next = SAHP_CONV;
          bitPtr_next = {1'b1, {(RES_W-1){1'b0}}};
          trial_next = {1'b1, {(RES_W-1){1'b0}}};
          stepCnt_next = 4'h0;
        end else begin
          // offset binary from the array flips its msb into two's complement
          result_next = {~trial_reg[RES_W-1], trial_reg[RES_W-2:0]};
          state_next = SAHP_IDLE;
        end
      end
      default: begin
        state_next = SAHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= SAHP_IDLE;
      trial_reg <= RESULT_RST;
      bitPtr_reg <= RESULT_RST;
      result_reg <= RESULT_RST;
      stepCnt_reg <= 4'h0;
    end else if (clkEn) begin
      state_reg <= state_next;
      trial_reg <= trial_next;
      bitPtr_reg <= bitPtr_next;
      result_reg <= result_next;
      stepCnt_reg <= stepCnt_next;
    end
  end

  assign dacCode = trial_reg;
  assign sampleHold = (state_reg != SAHP_IDLE);

  // busy low from the start until the result register has been written
  // busy comes from the state register alone, so it cannot glitch mid-step
  assign busyN = (state_reg == SAHP_IDLE);

  // --------------------------------------------------------------------------
  // three-state output drivers
  // --------------------------------------------------------------------------
  logic [RES_W-1:0] dOut_reg, dOut_next;
  logic dOe_reg, dOe_next;

  // drive only while select low and read/convert high; with byte select high
  // the two halves swap, so the low result byte moves onto lanes 15..8
  // the enable trails the pins by three edges (two sync flops and this
  // register), so a host must allow that much access time after opening the bus
  always_comb begin
    dOe_next = ~pins.csN & pins.readConvN;
    if (pins.byteSel) begin
      dOut_next = {result_reg[BYTE_W-1:0], result_reg[RES_W-1:BYTE_W]};
    end else begin
      dOut_next = result_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dOut_reg <= RESULT_RST;
      dOe_reg <= 1'b0;
    end else if (clkEn) begin
      dOut_reg <= dOut_next;
      dOe_reg <= dOe_next;
    end
  end

  assign dataBus.dataOut = dOut_reg;
  assign dataBus.dataOe = {RES_W{dOe_reg}};
endmodule

//--- design/sahp_pkg.sv
// shared constants and types for the converter host port
// ----------------------------------------------------------------------------
// How it works
// - busy output goes low when a conversion begins and stays low until the result is updated.
// - byte select low presents the upper result byte, high presents the lower result byte.
// - device select and read/convert are ORed; with read/convert low a select fall starts.
// - data outputs float whenever device select is high or read/convert is low.
// - with byte select low, the result msb appears on data bit 15, lower bits on lower data bits.
// - with select low and busy high a read/convert fall starts; a rise enables output.
// - a convert command arriving while busy is low aborts and restarts the converter.
// - each 16-bit result is presented in two's complement form.
// ----------------------------------------------------------------------------
package sahp_pkg;
  localparam int RES_W = 16;
  localparam int BYTE_W = 8;
  // least start pulse, in ns, and its cycle count at 200 MHz (rounded up)
  localparam int START_MIN_NS = 40;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int START_CYC = (START_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // cycles one successive-approximation step takes (internal clock model)
  localparam int STEP_CYC = 4;
  localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;

  typedef enum logic [2:0] {
    SAHP_IDLE = 3'b001,
    SAHP_CONV = 3'b010,
    SAHP_DONE = 3'b100
  } sahp_state_t;

  // host pins after synchronisation
  typedef struct packed {
    logic csN;
    logic readConvN;
    logic byteSel;
  } sahp_pins_t;

  // data bus toward the pins
  typedef struct packed {
    logic [RES_W-1:0] dataOut;
    logic [RES_W-1:0] dataOe;
  } sahp_bus_t;
endpackage

//--- design/sahp_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module sahp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else if (clkEn) begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
    end
  end

  assign syncOut = sync_reg;
endmodule

//--- verification/sahp_comp_model.sv
// comparator model standing in for the sampled analog input
`timescale 1ns/1ps
module sahp_comp_model (
  input wire logic [sahp_pkg::RES_W-1:0] dacCode,
  input wire logic [sahp_pkg::RES_W-1:0] target,
  output logic compIn
);
  // answers at once; the sequencer only samples it a whole step after the trial moves
  assign compIn = (dacCode <= target);
endmodule

//--- verification/sahp_host_port_monitor.sv
// pin-level assertions for the converter host port
`timescale 1ns/1ps
module sahp_host_port_monitor (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic csN,
  input wire logic readConvN,
  input wire logic sampleHold,
  input wire logic busyN,
  input wire sahp_pkg::sahp_bus_t dataBus
);
  import sahp_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  // a frozen clock enable stretches every timing, so attempts spanning it are dropped
  default disable iff (srst || !clkEn);
  // four cycles cover the two sync flops plus the output register
  oe_cs_off_a: assert property (csN[*4] |-> dataBus.dataOe == '0)
    else $error("bus driven while deselected");
  oe_rc_off_a: assert property (!readConvN[*4] |-> dataBus.dataOe == '0)
    else $error("bus driven in convert mode");
  oe_read_a: assert property ((!csN && readConvN)[*4] |-> &dataBus.dataOe)
    else $error("bus idle in read mode");
  start_cause_a: assert property ($fell(busyN) |-> $past(csN | readConvN, 3) == 1'b0)
    else $error("busy fell without command");
  busy_hold_a: assert property ($fell(busyN) |-> !busyN[*8])
    else $error("busy pulse too short");
  // a full conversion keeps busy low for all steps plus the result write
  busy_len_a: assert property ($rose(busyN) |-> !$past(busyN, 65))
    else $error("conversion ended early");
  // once the command is released busy must return unless a new command comes
  conv_bound_a: assert property ($rose(csN | readConvN) |-> ##[1:70] (busyN || !(csN | readConvN)))
    else $error("conversion never ends");
  no_spur_a: assert property (((csN | readConvN)[*4] ##0 busyN) |=> busyN)
    else $error("busy fell while idle");
  cv_conv_c: cover property ($fell(busyN) ##[60:70] $rose(busyN));
  cv_abort_c: cover property (!busyN && !csN && !readConvN);
  cv_read_c: cover property (&dataBus.dataOe);
endmodule
bind sahp_host_port sahp_host_port_monitor mon (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .csN(csN),
  .readConvN(readConvN), .sampleHold(sampleHold), .busyN(busyN), .dataBus(dataBus));

//--- verification/sahp_host_port_tb_top.sv
// self-checking testbench for the converter host port
`timescale 1ns/1ps
module sahp_host_port_tb_top;
  import sahp_pkg::*;
  logic ref_clk = 0;
  logic srst = 1;
  logic clkEn = 1;
  logic csN = 1;
  logic readConvN = 1;
  logic byteSel = 0;
  logic compIn;
  logic [RES_W-1:0] dacCode;
  logic [RES_W-1:0] target = '0;
  logic sampleHold;
  logic busyN;
  sahp_bus_t dataBus;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  sahp_host_port dut (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .csN(csN),
    .readConvN(readConvN), .byteSel(byteSel), .compIn(compIn), .dacCode(dacCode),
    .sampleHold(sampleHold), .busyN(busyN), .dataBus(dataBus));
  sahp_comp_model cmp (.dacCode(dacCode), .target(target), .compIn(compIn));
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one pin low first, the other falls; held past the start filter, then both released
  task automatic start(logic [RES_W-1:0] t, bit csLast);
    target <= t;
    if (csLast) readConvN <= 0; else csN <= 0;
    tick(2);
    csN <= 0;
    readConvN <= 0;
    tick(14);
    check("oe convert", 0, dataBus.dataOe);
    check("busy low", 0, busyN);
    check("hold", 1, sampleHold);
    csN <= 1;
    readConvN <= 1;
  endtask
  // wait for the result, then read the word and the swapped byte view
  task automatic read(logic [RES_W-1:0] t);
    int i;
    for (i = 0; i < 200 && busyN !== 1'b1; i++) tick(1);
    check("busy end", 1, busyN);
    check("track", 0, sampleHold);
    check("oe deselect", 0, dataBus.dataOe);
    csN <= 0;
    tick(4);
    check("word", t ^ 16'h8000, dataBus.dataOut);
    check("oe read", 16'hffff, dataBus.dataOe);
    byteSel <= 1;
    tick(4);
    check("bytes", {t[7:0], t[15:8] ^ 8'h80}, dataBus.dataOut);
    byteSel <= 0;
    csN <= 1;
    tick(4);
  endtask
  task automatic t_conv(logic [RES_W-1:0] t, bit csLast);
    start(t, csLast);
    read(t);
    $display("test conv %h done", t);
  endtask
  // second command mid-conversion must restart, so busy outlasts the first
  task automatic t_abort();
    start(16'h1234, 0);
    tick(30);
    start(16'h4321, 1);
    tick(25);
    check("busy restart", 0, busyN);
    read(16'h4321);
    $display("test abort done");
  endtask
  // select tied low: read/convert alone starts the conversion and opens the bus
  task automatic t_tied(logic [RES_W-1:0] t);
    int i;
    target <= t;
    csN <= 0;
    tick(4);
    readConvN <= 0;
    tick(14);
    check("tied busy", 0, busyN);
    check("tied oe conv", 0, dataBus.dataOe);
    readConvN <= 1;
    tick(4);
    check("tied oe read", 16'hffff, dataBus.dataOe);
    for (i = 0; i < 200 && busyN !== 1'b1; i++) tick(1);
    tick(2);
    check("tied word", t ^ 16'h8000, dataBus.dataOut);
    csN <= 1;
    tick(4);
    $display("test tied done");
  endtask
  // clock enable low must hold the conversion where it stands
  task automatic t_freeze(logic [RES_W-1:0] t);
    start(t, 1);
    clkEn <= 0;
    tick(100);
    check("frozen busy", 0, busyN);
    clkEn <= 1;
    read(t);
    $display("test freeze done");
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // about 790 cycles are needed; the ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    tick(10);
    srst <= 0;
    tick(1);
    t_conv(16'h0000, 0);
    t_conv(16'h7fff, 1);
    t_conv(16'h8000, 0);
    t_conv(16'hffff, 1);
    t_abort();
    t_tied(16'h5a5a);
    t_freeze(16'h00ff);
    end_of_test();
  end
endmodule
